// >>> rtl/shcmd_params.svh
`ifndef SHCMD_PARAMS_SVH
`define SHCMD_PARAMS_SVH

`define SHCMD_FAM_RDREG      8'h41
`define SHCMD_FAM_ATTR       8'h42
`define SHCMD_FAM_DUMP       8'h43
`define SHCMD_FAM_ENABLE     8'h44

`define SHCMD_IDX_OPTICAL    3'h0
`define SHCMD_IDX_TEMP       3'h1
`define SHCMD_IDX_ECG        3'h2
`define SHCMD_IDX_SPO2       3'h3
`define SHCMD_IDX_ACCEL      3'h4
`define SHCMD_NUM_SENSORS    5

`define SHCMD_VAL_DISABLE    8'h00
`define SHCMD_VAL_ENABLE     8'h01

`define SHCMD_STS_OK         8'h00
`define SHCMD_STS_BAD_CMD    8'h01
`define SHCMD_STS_NO_SENSOR  8'h02
`define SHCMD_STS_BUSY       8'h03

`define SHCMD_CLK_HZ         50000000
`define SHCMD_SETTLE_OPT_MS  250
`define SHCMD_SETTLE_TMP_MS  20
`define SHCMD_SETTLE_ECG_MS  20
`define SHCMD_SETTLE_SPO_MS  40
`define SHCMD_SETTLE_ACC_MS  20
`define SHCMD_MS_CYCLES      (`SHCMD_CLK_HZ / 1000)

`endif

// >>> rtl/shcmd_pkg.sv
package shcmd_pkg;
   // One byte on the host command stream
   typedef struct packed {
      logic [7:0] data;
      logic       last;
   } shcmd_byte_t;

   // Access to the attached sensor registers
   typedef struct packed {
      logic [2:0] sensor;
      logic [7:0] addr;
   } shcmd_sreq_t;

   typedef enum logic [2:0] {
      SHCMD_IDLE   = 3'b000,
      SHCMD_ARGS   = 3'b001,
      SHCMD_RDREQ  = 3'b010,
      SHCMD_RDWAIT = 3'b011,
      SHCMD_RESP   = 3'b100,
      SHCMD_DUMP   = 3'b101,
      SHCMD_FLUSH  = 3'b110
   } shcmd_state_t;
endpackage

// >>> rtl/shcmd_sensor_cmds.sv
// Behaviour
// - Family 0x41 takes an index and one address byte and returns the register value, index 0x02 is ECG.
// - In family 0x41 index 0x03 reads the pulse-oximetry sensor and 0x04 the accelerometer.
// - Family 0x42 takes no write bytes and returns word width in bytes then register count.
// - Attribute index 0x00..0x04 selects optical, temperature, ECG, pulse-oximetry, accelerometer.
// - Family 0x43 takes no write bytes and returns address then value for every register in order.
// - Dump with index 0x01 covers the temperature sensor and 0x02 the ECG front end.
// - Dump with index 0x04 streams accelerometer pairs and 0x03 pulse-oximetry pairs.
// - Family 0x44 takes one byte, 0x00 disables, 0x01 enables, optical index needs 250ms settle.
// - Enable index 0x01 switches the temperature sensor and needs 20ms settle.
// - Enable index 0x02 switches the ECG front end and needs 20ms settle.
// - Enable index 0x03 switches the pulse-oximetry sensor and needs 40ms settle.
`include "shcmd_params.svh"
module shcmd_sensor_cmds
   import shcmd_pkg::*;
#(
   parameter logic [4:0]  PRESENT_MASK = 5'h1f,
   parameter logic [39:0] WORD_BYTES   = 40'h01_01_03_01_01,
   parameter logic [39:0] REG_COUNT    = 40'h40_40_40_08_40,
   parameter int          SETTLE_DIV   = `SHCMD_MS_CYCLES
) (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire shcmd_byte_t cmd_in,
   input  wire logic        cmd_valid,
   output logic             cmd_ready,
   output shcmd_byte_t      rsp_out,
   output logic             rsp_valid,
   input  wire logic        rsp_ready,
   output shcmd_sreq_t      sreq,
   output logic             sreq_valid,
   input  wire logic        sreq_ack,
   input  wire logic [7:0]  sreq_rdata,
   output logic [4:0]       sensor_en,
   output logic             busy
);
   localparam int MS_W = $clog2(SETTLE_DIV + 1);

   // Refused at elaboration, a zero divider would never end a settle
   if (SETTLE_DIV < 1) begin : g_bad_div
      $error("SETTLE_DIV must be at least one");
   end

   // ==========================================
   // Command decode state
   shcmd_state_t state_r;
   logic [7:0]   fam_r;
   logic [2:0]   idx_r;
   logic         idx_bad_r;
   logic [1:0]   argc_r;
   logic [7:0]   arg_r;
   logic [7:0]   rd_val_r;
   logic [7:0]   dump_addr_r;
   logic         dump_half_r;
   logic [1:0]   rsp_cnt_r;
   logic [7:0]   sreq_addr_r;
   logic         sreq_valid_r;
   logic [4:0]   sensor_en_r;
   logic [8:0]   settle_ms_r;
   logic [MS_W-1:0] ms_cnt_r;

   // Two-entry skid buffer on the answer path
   shcmd_byte_t  buf_r [2];
   logic [1:0]   buf_cnt_r;
   shcmd_byte_t  push_data;
   logic         push;
   logic         buf_space;
   logic         pop;
   logic         rsp_valid_r;

   assign buf_space = (buf_cnt_r != 2'd2);
   assign pop       = (buf_cnt_r != 2'd0) && rsp_ready;

   logic [7:0] reg_cnt;
   logic [7:0] word_bytes;
   assign reg_cnt    = REG_COUNT[idx_r*8 +: 8];
   assign word_bytes = WORD_BYTES[idx_r*8 +: 8];

   logic take;
   assign take = cmd_valid && cmd_ready;

   logic [7:0] settle_ms;
   always_comb begin
      unique case (idx_r)
         `SHCMD_IDX_OPTICAL: settle_ms = 8'(`SHCMD_SETTLE_OPT_MS);
         `SHCMD_IDX_TEMP:    settle_ms = 8'(`SHCMD_SETTLE_TMP_MS);
         `SHCMD_IDX_ECG:     settle_ms = 8'(`SHCMD_SETTLE_ECG_MS);
         `SHCMD_IDX_SPO2:    settle_ms = 8'(`SHCMD_SETTLE_SPO_MS);
         default:            settle_ms = 8'(`SHCMD_SETTLE_ACC_MS);
      endcase
   end

   // ==========================================
   // Answer byte selection
   always_comb begin
      push           = 1'b0;
      push_data.data = 8'h00;
      push_data.last = 1'b0;
      if (buf_space) begin
         unique case (state_r)
            SHCMD_RESP: begin
               push = 1'b1;
               if (fam_r == `SHCMD_FAM_ATTR && !idx_bad_r) begin
                  push_data.data = (rsp_cnt_r == 2'd0) ? word_bytes : reg_cnt;
                  push_data.last = (rsp_cnt_r == 2'd1);
               end else if (fam_r == `SHCMD_FAM_RDREG && !idx_bad_r) begin
                  push_data.data = rd_val_r;
                  push_data.last = 1'b1;
               end else begin
                  push_data.data = idx_bad_r ? `SHCMD_STS_NO_SENSOR : `SHCMD_STS_BAD_CMD;
                  push_data.last = 1'b1;
                  if (fam_r == `SHCMD_FAM_ENABLE && !idx_bad_r) begin
                     push_data.data = `SHCMD_STS_OK;
                  end
               end
            end
            SHCMD_DUMP: begin
               push           = dump_half_r || !sreq_valid_r;
               push_data.data = dump_half_r ? rd_val_r : dump_addr_r;
               push_data.last = dump_half_r && (dump_addr_r == reg_cnt - 8'd1);
            end
            default: push = 1'b0;
         endcase
      end
   end

   // ==========================================
   // Command sequencer
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_r      <= SHCMD_IDLE;
         fam_r        <= 8'h00;
         idx_r        <= 3'h0;
         idx_bad_r    <= 1'b0;
         argc_r       <= 2'd0;
         arg_r        <= 8'h00;
         rd_val_r     <= 8'h00;
         dump_addr_r  <= 8'h00;
         dump_half_r  <= 1'b0;
         rsp_cnt_r    <= 2'd0;
         sreq_addr_r  <= 8'h00;
         sreq_valid_r <= 1'b0;
      end else begin
         unique case (state_r)
            SHCMD_IDLE: if (take) begin
               fam_r     <= cmd_in.data;
               argc_r    <= 2'd0;
               rsp_cnt_r <= 2'd0;
               state_r   <= cmd_in.last ? SHCMD_RESP : SHCMD_ARGS;
               idx_bad_r <= 1'b1;
            end
            SHCMD_ARGS: if (take) begin
               argc_r <= argc_r + 2'd1;
               if (argc_r == 2'd0) begin
                  idx_r     <= cmd_in.data[2:0];
                  // Unknown or absent sensors never reach the sensor bus
                  idx_bad_r <= (cmd_in.data > 8'h04) || !PRESENT_MASK[cmd_in.data[2:0]];
               end else begin
                  arg_r <= cmd_in.data;
               end
               if (cmd_in.last) begin
                  if (idx_bad_r && argc_r != 2'd0) state_r <= SHCMD_RESP;
                  else if (argc_r == 2'd0 && ((cmd_in.data > 8'h04) || !PRESENT_MASK[cmd_in.data[2:0]]))
                     state_r <= SHCMD_RESP;
                  else if (fam_r == `SHCMD_FAM_RDREG && argc_r == 2'd1) begin
                     sreq_addr_r  <= cmd_in.data;
                     sreq_valid_r <= 1'b1;
                     state_r      <= SHCMD_RDWAIT;
                  end else if (fam_r == `SHCMD_FAM_DUMP && argc_r == 2'd0) begin
                     dump_addr_r <= 8'h00;
                     dump_half_r <= 1'b0;
                     state_r     <= SHCMD_DUMP;
                  end else begin
                     // Good indices left by the branches above
                     idx_bad_r <= 1'b0;
                     state_r   <= SHCMD_RESP;
                     if (!((fam_r == `SHCMD_FAM_ATTR && argc_r == 2'd0) ||
                           (fam_r == `SHCMD_FAM_ENABLE && argc_r == 2'd1 && cmd_in.data <= 8'h01)))
                        fam_r <= 8'h00;
                  end
               end
            end
            SHCMD_RDWAIT: if (sreq_ack) begin
               sreq_valid_r <= 1'b0;
               rd_val_r     <= sreq_rdata;
               state_r      <= SHCMD_RESP;
            end
            SHCMD_RESP: if (push) begin
               rsp_cnt_r <= rsp_cnt_r + 2'd1;
               if (push_data.last) state_r <= SHCMD_FLUSH;
            end
            SHCMD_DUMP: begin
               if (!dump_half_r && !sreq_valid_r && push) begin
                  sreq_addr_r  <= dump_addr_r;
                  sreq_valid_r <= 1'b1;
               end else if (sreq_valid_r && sreq_ack) begin
                  sreq_valid_r <= 1'b0;
                  rd_val_r     <= sreq_rdata;
                  dump_half_r  <= 1'b1;
               end else if (dump_half_r && push) begin
                  dump_half_r <= 1'b0;
                  dump_addr_r <= dump_addr_r + 8'd1;
                  if (push_data.last) state_r <= SHCMD_FLUSH;
               end
            end
            SHCMD_FLUSH: if (ms_cnt_r == '0 && settle_ms_r == 9'd0) state_r <= SHCMD_IDLE;
            default: state_r <= SHCMD_IDLE;
         endcase
      end
   end

   // ==========================================
   // Sensor enables and settle timer
   // Busy is held through settle and cmd_ready stays low, so a host that ignores it is stalled
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sensor_en_r <= 5'h00;
         settle_ms_r <= 9'd0;
         ms_cnt_r    <= '0;
      end else if (state_r == SHCMD_RESP && push && fam_r == `SHCMD_FAM_ENABLE && !idx_bad_r) begin
         sensor_en_r[idx_r] <= (arg_r == `SHCMD_VAL_ENABLE);
         settle_ms_r        <= {1'b0, settle_ms};
         ms_cnt_r           <= MS_W'(SETTLE_DIV - 1);
      end else if (settle_ms_r != 9'd0) begin
         if (ms_cnt_r == '0) begin
            settle_ms_r <= settle_ms_r - 9'd1;
            ms_cnt_r    <= (settle_ms_r == 9'd1) ? '0 : MS_W'(SETTLE_DIV - 1);
         end else begin
            ms_cnt_r <= ms_cnt_r - MS_W'(1);
         end
      end
   end

   // ==========================================
   // Answer buffer
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         buf_cnt_r   <= 2'd0;
         rsp_valid_r <= 1'b0;
         buf_r[0]    <= '0;
         buf_r[1]    <= '0;
      end else begin
         if (pop) buf_r[0] <= buf_r[1];
         if (push) buf_r[(pop ? buf_cnt_r - 2'd1 : buf_cnt_r) == 2'd0 ? 0 : 1] <= push_data;
         buf_cnt_r   <= buf_cnt_r + {1'b0, push} - {1'b0, pop};
         // Registered copy keeps the valid output straight off a flop
         rsp_valid_r <= (buf_cnt_r + {1'b0, push} - {1'b0, pop}) != 2'd0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) cmd_ready <= 1'b0;
      else cmd_ready <= (state_r == SHCMD_IDLE || state_r == SHCMD_ARGS) && !(take && cmd_in.last);
   end

   always_ff @(posedge sys_clk) begin
      if (rst) busy <= 1'b0;
      else busy <= (state_r != SHCMD_IDLE) || take;
   end

   assign rsp_out    = buf_r[0];
   assign rsp_valid  = rsp_valid_r;
   assign sreq       = '{sensor: idx_r, addr: sreq_addr_r};
   assign sreq_valid = sreq_valid_r;
   assign sensor_en  = sensor_en_r;
endmodule

// >>> testbench/shcmd_sensor_cmds_props.sv
// ==========
// Port checks
module shcmd_sensor_cmds_props
   import shcmd_pkg::*;
#(
   parameter logic [4:0] PRESENT_MASK = 5'h1f
) (
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire shcmd_byte_t cmd_in,
   input wire logic        cmd_valid,
   input wire logic        cmd_ready,
   input wire shcmd_byte_t rsp_out,
   input wire logic        rsp_valid,
   input wire logic        rsp_ready,
   input wire shcmd_sreq_t sreq,
   input wire logic        sreq_valid,
   input wire logic        sreq_ack,
   input wire logic [7:0]  sreq_rdata,
   input wire logic [4:0]  sensor_en,
   input wire logic        busy
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_rst_quiet: assert property (disable iff (1'b0) rst |=> !cmd_ready && !rsp_valid && !sreq_valid && sensor_en == 5'h00 && !busy) else $error("outputs active after reset");
   a_sreq_hold: assert property (sreq_valid && !sreq_ack |=> sreq_valid && $stable(sreq)) else $error("sensor request dropped early");
   a_rsp_hold: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_out)) else $error("answer byte lost in stall");
   a_ready_drop: assert property (cmd_valid && cmd_ready && cmd_in.last |=> !cmd_ready) else $error("ready after final byte");
   a_en_one_bit: assert property (!$past(rst) |-> $onehot0(sensor_en ^ $past(sensor_en))) else $error("several enables moved");
   a_sreq_present: assert property (sreq_valid |-> sreq.sensor <= 3'h4 && PRESENT_MASK[sreq.sensor]) else $error("access to absent sensor");
   a_sreq_in_cmd: assert property ($rose(sreq_valid) |-> busy) else $error("sensor access outside a command");
   a_read_answer: assert property (sreq_valid && sreq_ack |-> ##[1:4] rsp_valid) else $error("no answer after register read");
   a_idle_no_sreq: assert property (!busy |-> !sreq_valid) else $error("sensor access while idle");
endmodule

bind shcmd_sensor_cmds shcmd_sensor_cmds_props #(.PRESENT_MASK(PRESENT_MASK)) u_props (.sys_clk(sys_clk), .rst(rst),
   .cmd_in(cmd_in), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .rsp_out(rsp_out), .rsp_valid(rsp_valid),
   .rsp_ready(rsp_ready), .sreq(sreq), .sreq_valid(sreq_valid), .sreq_ack(sreq_ack), .sreq_rdata(sreq_rdata),
   .sensor_en(sensor_en), .busy(busy));

// >>> testbench/shcmd_sensor_model.sv
// ==========
// Attached sensors
module shcmd_sensor_model
   import shcmd_pkg::*;
(
   input wire logic        sys_clk,
   input wire shcmd_sreq_t sreq,
   input wire logic        sreq_valid,
   output logic            sreq_ack,
   output logic [7:0]      sreq_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] wait_cnt;
   initial begin
      sreq_ack = 1'b0;
      sreq_rdata = 8'h00;
      wait_cnt = 2'h0;
   end
   // Delay follows the address so waits vary
   always @(posedge sys_clk) begin
      #1;
      if (sreq_ack) begin
         sreq_ack = 1'b0;
         sreq_rdata = ~sreq_rdata; // Stale data never looks valid
         wait_cnt = 2'h0;
      end else if (sreq_valid) begin
         if (wait_cnt == sreq.addr[1:0]) begin
            sreq_ack = 1'b1;
            sreq_rdata = sreq.addr ^ {sreq.sensor, 5'h0a};
         end else wait_cnt++;
      end
   end
endmodule

// >>> testbench/tb.sv
`include "shcmd_params.svh"
module tb
   import shcmd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int          SD = 5;
   localparam logic [39:0] WB = 40'h01_01_03_01_01;
   localparam logic [39:0] RC = 40'h04_03_05_02_03;
   logic        sys_clk = 0, rst = 1, cmd_valid = 0, rsp_ready = 0;
   logic        cmd_ready, rsp_valid, sreq_valid, sreq_ack, busy;
   shcmd_byte_t cmd_in = '0, rsp_out;
   shcmd_sreq_t sreq;
   logic [7:0]  sreq_rdata;
   logic [4:0]  sensor_en;
   logic [31:0] seed = 32'h51763584;
   int          bad_count = 0, total_checks = 0, cyc = 0;
   shcmd_byte_t exp_q[$];

   shcmd_sensor_cmds #(.REG_COUNT(RC), .SETTLE_DIV(SD)) dut (.sys_clk(sys_clk), .rst(rst), .cmd_in(cmd_in),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .rsp_out(rsp_out), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
      .sreq(sreq), .sreq_valid(sreq_valid), .sreq_ack(sreq_ack), .sreq_rdata(sreq_rdata), .sensor_en(sensor_en),
      .busy(busy));
   shcmd_sensor_model u_model (.sys_clk(sys_clk), .sreq(sreq), .sreq_valid(sreq_valid), .sreq_ack(sreq_ack),
      .sreq_rdata(sreq_rdata));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [7:0] rv(input logic [2:0] i, input logic [7:0] a);
      return a ^ {i, 5'h0a};
   endfunction
   function automatic int sms(input logic [2:0] i);
      case (i)
         3'h0: return `SHCMD_SETTLE_OPT_MS;
         3'h1: return `SHCMD_SETTLE_TMP_MS;
         3'h2: return `SHCMD_SETTLE_ECG_MS;
         3'h3: return `SHCMD_SETTLE_SPO_MS;
         default: return `SHCMD_SETTLE_ACC_MS;
      endcase
   endfunction
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      total_checks++;
      if (e !== s) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic exp(input logic [7:0] d, input logic l);
      exp_q.push_back('{data: d, last: l});
   endtask
   // Byte is taken at the edge after ready is seen settled
   task automatic put(input logic [7:0] d, input logic l);
      cmd_in = '{data: d, last: l};
      cmd_valid = 1'b1;
      while (cmd_ready !== 1'b1) begin @(posedge sys_clk); #1; end
      @(posedge sys_clk);
      #1;
   endtask
   task automatic run(input logic [7:0] f, input logic [7:0] i, input logic [7:0] a);
      int  t0;
      logic ok;
      logic arg;
      ok = i < 8'h05;
      arg = f == 8'h41 || f == 8'h44;
      if (f < 8'h41 || f > 8'h44) exp(8'h01, 1'b1);
      else if (!ok) exp(8'h02, 1'b1);
      else case (f)
         8'h41: exp(rv(i[2:0], a), 1'b1);
         8'h42: begin exp(WB[i*8+:8], 1'b0); exp(RC[i*8+:8], 1'b1); end
         8'h43: for (int r = 0; r < RC[i*8+:8]; r++) begin
            exp(r[7:0], 1'b0);
            exp(rv(i[2:0], r[7:0]), r == RC[i*8+:8] - 1);
         end
         default: exp(8'h00, 1'b1);
      endcase
      put(f, 1'b0);
      put(i, !arg);
      if (arg) put(a, 1'b1);
      t0 = cyc;
      cmd_valid = 1'b0;
      chk("busy", 8'h01, {7'h0, busy});
      while (cmd_ready !== 1'b1 || exp_q.size() != 0) begin @(posedge sys_clk); #1; end
      chk("busy", 8'h00, {7'h0, busy});
      if (f == 8'h44 && ok) begin
         chk("settle", 8'((cyc - t0) >= sms(i[2:0]) * SD), 8'h01);
         chk("sensor_en", {7'h0, a[0]}, {7'h0, sensor_en[i[2:0]]});
      end
   endtask

   // ==========
   // Clock, stalls, watch
   initial forever #10 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin bad_count++; results(); end
   end
   always @(posedge sys_clk) begin
      #1;
      seed = lfsr(seed);
      rsp_ready = seed[0] | seed[3]; // Frequent stalls fill the buffer
   end
   always @(posedge sys_clk) if (!rst && rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
      total_checks++;
      if (exp_q.size() == 0 || rsp_out !== exp_q[0]) begin
         bad_count++;
         $display("ERROR rsp_out expected %h seen %h", exp_q.size() ? exp_q[0] : 9'h0, rsp_out);
      end
      if (exp_q.size() != 0) void'(exp_q.pop_front());
   end

   // ==========
   // Tests
   initial begin
      repeat (16) @(posedge sys_clk);
      #1 rst = 1'b0;
      for (int i = 0; i < 5; i++) run(8'h41, i[7:0], seed[15:8]);
      $display("test read done");
      for (int i = 0; i < 5; i++) run(8'h42, i[7:0], 8'h00);
      $display("test attributes done");
      for (int i = 0; i < 5; i++) run(8'h43, i[7:0], 8'h00);
      $display("test dump done");
      for (int i = 0; i < 5; i++) begin run(8'h44, i[7:0], 8'h01); run(8'h44, i[7:0], 8'h00); end
      $display("test enable done");
      run(8'h47, 8'h00, 8'h00);
      run(8'h41, 8'h05, 8'h10);
      run(8'h42, 8'h07, 8'h00);
      $display("test reject done");
      run(8'h44, 8'h01, 8'h01);
      rst = 1'b1;
      repeat (3) @(posedge sys_clk);
      #1 rst = 1'b0;
      chk("sensor_en", 8'h00, {3'h0, sensor_en});
      run(8'h41, 8'h02, 8'h05);
      $display("test reset done");
      results();
   end
endmodule
